/* File: pss_pkg.sv */
package pss_pkg;
  localparam int unsigned CORE_CLK_MHZ      = 200;
  localparam int unsigned XO_SETTLE_MS      = 5;
  localparam int unsigned XO_SETTLE_CYCLES  = XO_SETTLE_MS * 1000 * CORE_CLK_MHZ;
  localparam int unsigned STEP_GAP_CYCLES   = 1;
  localparam int unsigned CNT_W             = 32;
  localparam int unsigned PIN_W             = 8;
  localparam logic [PIN_W-1:0] PIN_RST_VAL  = 8'h00;

  typedef enum logic [5:0]
  {
    PSS_POWER_DOWN          = 6'h01,
    PSS_IDLE_ON             = 6'h02,
    PSS_WLAN_TX_STATE       = 6'h04,
    PSS_WLAN_RX_STATE       = 6'h08,
    PSS_SHORT_RADIO_TX_STATE = 6'h10,
    PSS_SHORT_RADIO_RX_STATE = 6'h20
  } pss_dev_state_t;

  typedef enum logic [2:0]
  {
    PSS_PIN_OFF     = 3'h1,
    PSS_PIN_RESET   = 3'h2,
    PSS_PIN_DEFAULT = 3'h4
  } pss_pin_phase_t;

  typedef enum logic [7:0]
  {
    PSS_SQ_OFF      = 8'h01,
    PSS_SQ_BAT_ON   = 8'h02,
    PSS_SQ_IO_ON    = 8'h04,
    PSS_SQ_EN_HIGH  = 8'h08,
    PSS_SQ_WAIT_XO  = 8'h10,
    PSS_SQ_RUN      = 8'h20,
    PSS_SQ_DOWN_IO  = 8'h40,
    PSS_SQ_DOWN_BAT = 8'h80
  } pss_seq_state_t;
endpackage

/* File: pss_if.sv */
`timescale 1ns/100ps
interface pss_if;
  logic bat_supply;
  logic io_supply;
  logic core_en;
  logic hard_reset_low;

  modport dev
  (
    input bat_supply,
    input io_supply,
    input core_en,
    input hard_reset_low
  );
  modport ctl
  (
    output bat_supply,
    output io_supply,
    output core_en,
    output hard_reset_low
  );
endinterface

/* File: pss_device.sv */
`timescale 1ns/100ps
// Overview of operation
// R1: Track six states, radios, idle, power-down.
// R2: On states need io supply and enable.
// R3: Host switches on/off only by enable.
// R4: Enable high turns on core converter.
// R5: Enable never rises before io supply.
// R6: Reset held 5 ms after enable rise.
// R7: Enable and reset always driven defined.
// R8: Enable and reset drop by io fall.
// R9: Io supply stays until reset low.
// R10: Io after battery up, before battery down.
// R11: Power-down keeps core supply off; code reports PSS_POWER_DOWN with core supply on while reset is held.
// R12: Io off, enable low: fully unpowered.
// R13: Driving pins when low-power needs io on.
// R14: In reset: hi-z, inputs off, pulls on.
// R15: Unprogrammed: hi-z, inputs on, pulls on.
// R16: Programmed: per-pin driver and pull control.
// R17: Programmed: input buffer opposite of driver.
// R18: Up: supplies, enable, wait, reset; down reversed.
module pss_device
  import pss_pkg::*;
(
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst_n,
  pss_if.dev                             link,
  input  wire logic                      i_fw_cfg_done,
  input  wire logic [pss_pkg::PIN_W-1:0] i_fw_out_en,
  input  wire logic [pss_pkg::PIN_W-1:0] i_fw_pull_en,
  input  wire logic                      i_wlan_tx,
  input  wire logic                      i_wlan_rx,
  input  wire logic                      i_sr_tx,
  input  wire logic                      i_sr_rx,
  output logic                           o_core_supply_on,
  output logic                           o_core_rst_n,
  output pss_pkg::pss_dev_state_t        o_dev_state,
  output pss_pkg::pss_pin_phase_t        o_pin_phase,
  output logic [pss_pkg::PIN_W-1:0]      o_pin_out_en,
  output logic [pss_pkg::PIN_W-1:0]      o_pin_in_en,
  output logic [pss_pkg::PIN_W-1:0]      o_pin_pull_en
);
  import pss_pkg::*;

  logic [3:0]       pin_raw;
  wire  [3:0]       pin_sync;
  wire  [PIN_W-1:0] pin_out_w;
  wire  [PIN_W-1:0] pin_in_w;
  wire  [PIN_W-1:0] pin_pull_w;
  logic             io_on;
  logic             en_on;
  logic             rst_hi;
  logic             cfg_q;
  logic             powered;

  // Link pins, battery first
  assign pin_raw = {link.bat_supply, link.io_supply, link.core_en, link.hard_reset_low};

  // Two-stage synchroniser per link pin
  for (genvar s = 0; s < $bits(pin_raw); s++)
  begin : g_sync
    logic meta_q;
    logic stab_q;

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        meta_q <= 1'b0;
        stab_q <= 1'b0;
      end
      else
      begin
        meta_q <= pin_raw[s];
        stab_q <= meta_q;
      end
    end

    assign pin_sync[s] = stab_q;
  end

  assign io_on   = pin_sync[2] & pin_sync[3];
  assign en_on   = pin_sync[1];
  assign rst_hi  = pin_sync[0];
  assign powered = io_on & en_on; // R2

  // Converter enable follows enable pin only while io and battery supply are up
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_core_supply_on <= 1'b0;
    else
      o_core_supply_on <= powered; // R4 R11 R12
  end

  // Core reset released only while powered
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_core_rst_n <= 1'b0;
    else
      o_core_rst_n <= powered & rst_hi;
  end

  // Firmware configured flag
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cfg_q <= 1'b0;
    else if (!(powered & rst_hi))
      cfg_q <= 1'b0;
    else if (i_fw_cfg_done)
      cfg_q <= 1'b1;
  end

  // Device state
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_dev_state <= PSS_POWER_DOWN;
    else if (!(powered & rst_hi))
      o_dev_state <= PSS_POWER_DOWN; // R1 R2
    else if (i_wlan_tx)
      o_dev_state <= PSS_WLAN_TX_STATE; // R1
    else if (i_wlan_rx)
      o_dev_state <= PSS_WLAN_RX_STATE; // R1
    else if (i_sr_tx)
      o_dev_state <= PSS_SHORT_RADIO_TX_STATE; // R1
    else if (i_sr_rx)
      o_dev_state <= PSS_SHORT_RADIO_RX_STATE; // R1
    else
      o_dev_state <= PSS_IDLE_ON; // R1
  end

  // Pin phase
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_pin_phase <= PSS_PIN_OFF;
    else if (!powered)
      o_pin_phase <= PSS_PIN_OFF; // R11
    else if (!rst_hi)
      o_pin_phase <= PSS_PIN_RESET; // R14
    else
      o_pin_phase <= PSS_PIN_DEFAULT; // R15 R16
  end

  // Per-pin driver, input buffer and pull
  for (genvar g = 0; g < PIN_W; g++)
  begin : g_pin
    logic out_q;
    logic in_q;
    logic pull_q;

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        out_q  <= PIN_RST_VAL[g];
        in_q   <= PIN_RST_VAL[g];
        pull_q <= PIN_RST_VAL[g];
      end
      else if (!powered)
      begin
        out_q  <= 1'b0; // R11
        in_q   <= 1'b0; // R12
        pull_q <= 1'b0; // R12
      end
      else if (!rst_hi)
      begin
        out_q  <= 1'b0; // R14
        in_q   <= 1'b0; // R14
        pull_q <= 1'b1; // R14
      end
      else if (!cfg_q)
      begin
        out_q  <= 1'b0; // R15
        in_q   <= 1'b1; // R15
        pull_q <= 1'b1; // R15
      end
      else
      begin
        out_q  <= i_fw_out_en[g]; // R16
        in_q   <= !i_fw_out_en[g]; // R17
        pull_q <= i_fw_pull_en[g]; // R16
      end
    end

    assign pin_out_w[g]  = out_q;
    assign pin_in_w[g]   = in_q;
    assign pin_pull_w[g] = pull_q;
  end

  // Pin controls straight from the per-pin flops
  assign o_pin_out_en  = pin_out_w;
  assign o_pin_in_en   = pin_in_w;
  assign o_pin_pull_en = pin_pull_w;
endmodule

/* File: pss_host.sv */
`timescale 1ns/100ps
module pss_host
  import pss_pkg::*;
#(
  parameter int unsigned XO_WAIT = pss_pkg::XO_SETTLE_CYCLES
)
(
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_n,
  pss_if.ctl                      link,
  input  wire logic               i_power_req,
  output logic                    o_ready,
  output logic                    o_off,
  output pss_pkg::pss_seq_state_t o_seq_state
);
  import pss_pkg::*;

  pss_seq_state_t        st_q;
  logic [CNT_W-1:0]      cnt_q;

  // Sequencer
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_q <= PSS_SQ_OFF;
    else
    begin
      case (st_q)
        PSS_SQ_OFF:      if (i_power_req) st_q <= PSS_SQ_BAT_ON; // R18
        PSS_SQ_BAT_ON:   st_q <= PSS_SQ_IO_ON; // R10
        PSS_SQ_IO_ON:    st_q <= PSS_SQ_EN_HIGH; // R5
        PSS_SQ_EN_HIGH:  st_q <= PSS_SQ_WAIT_XO;
        PSS_SQ_WAIT_XO:  if (!i_power_req) st_q <= PSS_SQ_DOWN_IO;
                         else if (cnt_q >= CNT_W'(XO_WAIT)) st_q <= PSS_SQ_RUN; // R6
        PSS_SQ_RUN:      if (!i_power_req) st_q <= PSS_SQ_DOWN_IO; // R3 R8
        PSS_SQ_DOWN_IO:  st_q <= PSS_SQ_DOWN_BAT; // R9
        PSS_SQ_DOWN_BAT: st_q <= PSS_SQ_OFF; // R10
        default:         st_q <= PSS_SQ_OFF;
      endcase
    end
  end

  // Settle counter from enable rise
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_q <= '0;
    else if (st_q == PSS_SQ_WAIT_XO)
      cnt_q <= cnt_q + CNT_W'(1);
    else
      cnt_q <= CNT_W'(STEP_GAP_CYCLES);
  end

  // Pins always driven from flops
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      link.bat_supply     <= 1'b0;
      link.io_supply      <= 1'b0;
      link.core_en        <= 1'b0; // R7
      link.hard_reset_low <= 1'b0; // R7
    end
    else
    begin
      link.bat_supply     <= !(st_q == PSS_SQ_OFF || st_q == PSS_SQ_DOWN_BAT);
      link.io_supply      <= (st_q == PSS_SQ_IO_ON) || (st_q == PSS_SQ_EN_HIGH)
                             || (st_q == PSS_SQ_WAIT_XO) || (st_q == PSS_SQ_RUN); // R13
      link.core_en        <= (st_q == PSS_SQ_EN_HIGH) || (i_power_req
                             && ((st_q == PSS_SQ_WAIT_XO) || (st_q == PSS_SQ_RUN))); // R3 R5 R8
      link.hard_reset_low <= (st_q == PSS_SQ_RUN) && i_power_req; // R6 R8 R9
    end
  end

  assign o_ready     = (st_q == PSS_SQ_RUN);
  assign o_off       = (st_q == PSS_SQ_OFF);
  assign o_seq_state = st_q;
endmodule

/* File: pss_monitor.sv */
`timescale 1ns/100ps
module pss_monitor
#(
  parameter int unsigned XO_WAIT = 20
)
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic bat_supply,
  input wire logic io_supply,
  input wire logic core_en,
  input wire logic hard_reset_low
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  int unsigned en_cnt_q;

  // Cycles with enable high
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      en_cnt_q <= 0;
    else if (!core_en)
      en_cnt_q <= 0;
    else if (en_cnt_q < XO_WAIT)
      en_cnt_q <= en_cnt_q + 1;
  end

  AST_EN_NEEDS_IO: assert property (core_en |-> io_supply)
    else $error("enable high without io supply");
  AST_IO_NEEDS_BAT: assert property (io_supply |-> bat_supply)
    else $error("io supply without battery");
  AST_RST_NEEDS_EN: assert property (hard_reset_low |-> core_en && io_supply)
    else $error("reset released without power");
  AST_XO_WAIT: assert property ($rose(hard_reset_low) |-> en_cnt_q >= XO_WAIT)
    else $error("reset released too early");
  AST_EN_AFTER_IO: assert property ($rose(core_en) |-> $past(io_supply))
    else $error("enable rose before io supply");
  AST_IO_FALL: assert property ($fell(core_en) |=> $fell(io_supply))
    else $error("io supply not dropped after enable");
  AST_BAT_FALL: assert property ($fell(io_supply) |-> ##1 $fell(bat_supply))
    else $error("battery not dropped after io");
  AST_IO_OFF_SAFE: assert property ($fell(io_supply) |-> !hard_reset_low && !core_en)
    else $error("io dropped before reset and enable");
  cover property ($rose(hard_reset_low));
  cover property ($fell(core_en) && !$past(hard_reset_low));
  cover property ($fell(bat_supply));
endmodule

/* File: power_state_sequencer_test.sv */
`timescale 1ns/100ps
`define CHK(a, b) \
  begin \
    n_tests++; \
    if ((a) !== (b)) \
    begin \
      fails++; \
      $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); \
    end \
  end
module power_state_sequencer_test;
  import pss_pkg::*;
  localparam int unsigned XO = 20;
  logic           i_core_clk = 1'b0;
  logic           i_rst_n    = 1'b0;
  logic           req        = 1'b0;
  logic           cfg        = 1'b0;
  logic [7:0]     fw_out     = 8'h00;
  logic [7:0]     fw_pull    = 8'h00;
  logic [3:0]     radio      = 4'h0;
  logic           core_on;
  logic           core_rst_n;
  pss_dev_state_t dev_state;
  pss_pin_phase_t phase;
  logic [7:0]     out_en;
  logic [7:0]     in_en;
  logic [7:0]     pull_en;
  logic           ready;
  logic           off;
  pss_seq_state_t seq;
  int             fails   = 0;
  int             n_tests = 0;
  pss_dev_state_t radio_st[4] = '{PSS_WLAN_TX_STATE, PSS_WLAN_RX_STATE,
                                  PSS_SHORT_RADIO_TX_STATE, PSS_SHORT_RADIO_RX_STATE};

  always #2.5 i_core_clk = ~i_core_clk;
  pss_if lnk();
  pss_device i_pss_device (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .link(lnk),
    .i_fw_cfg_done(cfg), .i_fw_out_en(fw_out), .i_fw_pull_en(fw_pull),
    .i_wlan_tx(radio[0]), .i_wlan_rx(radio[1]), .i_sr_tx(radio[2]), .i_sr_rx(radio[3]),
    .o_core_supply_on(core_on), .o_core_rst_n(core_rst_n), .o_dev_state(dev_state),
    .o_pin_phase(phase), .o_pin_out_en(out_en), .o_pin_in_en(in_en),
    .o_pin_pull_en(pull_en));
  pss_host #(.XO_WAIT(XO)) i_pss_host (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .link(lnk), .i_power_req(req), .o_ready(ready), .o_off(off), .o_seq_state(seq));
  pss_monitor #(.XO_WAIT(XO)) i_pss_monitor (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .bat_supply(lnk.bat_supply), .io_supply(lnk.io_supply), .core_en(lnk.core_en),
    .hard_reset_low(lnk.hard_reset_low));

  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Wait: 0 off, 1 ready, 2 oscillator wait
  task automatic wait_for(input int w);
    int k;
    k = 0;
    while (((w == 0) ? off : (w == 1) ? ready : (seq == PSS_SQ_WAIT_XO)) !== 1'b1
           && k < 200)
    begin
      cyc(1);
      k++;
    end
    if (k >= 200)
    begin
      fails++;
      test_done();
    end
  endtask

  task automatic pins(input logic [7:0] o, input logic [7:0] i, input logic [7:0] p);
    `CHK(out_en, o)
    `CHK(in_en, i)
    `CHK(pull_en, p)
  endtask

  initial
  begin
    cyc(12);
    i_rst_n = 1'b1;
    cyc(1);
    `CHK(dev_state, PSS_POWER_DOWN)
    `CHK(phase, PSS_PIN_OFF)
    $display("test reset done");
    req = 1'b1;
    wait_for(2);
    cyc(8);
    `CHK(core_on, 1'b1)
    `CHK(core_rst_n, 1'b0)
    `CHK(phase, PSS_PIN_RESET)
    pins(8'h00, 8'h00, 8'hff);
    req = 1'b0;
    wait_for(0);
    cyc(4);
    `CHK(core_on, 1'b0)
    $display("test abort done");
    req = 1'b1;
    wait_for(1);
    cyc(4);
    `CHK(core_rst_n, 1'b1)
    `CHK(dev_state, PSS_IDLE_ON)
    `CHK(phase, PSS_PIN_DEFAULT)
    pins(8'h00, 8'hff, 8'hff);
    for (int i = 0; i < 5; i++)
    begin
      radio = (i < 4) ? 4'h1 << i : 4'hf;
      cyc(4);
      `CHK(dev_state, radio_st[i % 4])
    end
    radio = 4'h0;
    cfg = 1'b1;
    fw_out = 8'h0f;
    fw_pull = 8'h33;
    cyc(4);
    pins(8'h0f, 8'hf0, 8'h33);
    fw_out = 8'ha5;
    cyc(4);
    pins(8'ha5, 8'h5a, 8'h33);
    $display("test power up done");
    req = 1'b0;
    wait_for(0);
    cyc(4);
    `CHK(dev_state, PSS_POWER_DOWN)
    `CHK(phase, PSS_PIN_OFF)
    pins(8'h00, 8'h00, 8'h00);
    $display("test power down done");
    test_done();
  end
endmodule
